// >>> hdl/byte_store_pkg.sv
package byte_store_pkg;

    // write timings scale with the clock, so they are kept as cycle counts
    // of the reference clock; a slower pclk stretches them in proportion
    localparam int REF_CLK_MHZ     = 20;
    localparam int WRITE_TIME_US   = 136;
    localparam int MAINT_TIME_MS   = 58;
    localparam int BADADDR_TIME_US = 7;
    localparam int WRITE_CYCLES    = WRITE_TIME_US * REF_CLK_MHZ;
    localparam int MAINT_CYCLES    = MAINT_TIME_MS * 1000 * REF_CLK_MHZ;
    localparam int BADADDR_CYCLES  = BADADDR_TIME_US * REF_CLK_MHZ;
    localparam int CNT_W           = 21;

    // store geometry and maintenance period
    localparam int       MAINT_PERIOD   = 200;
    localparam int       STORE_SIZE     = 64;
    localparam int       TRIM_COUNT     = 32;
    localparam logic [7:0] TRIM_INFO_BASE = 8'h20;
    localparam logic [7:0] ERASED_BYTE    = 8'hFF;
    localparam logic [7:0] TRIM_IDX_RESET = 8'h00;

    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_STORE_ADDR = 12'hFF0;
    localparam logic [11:0] IDX_STORE_DATA = 12'hFF1;
    localparam logic [11:0] IDX_CTRL       = 12'hFF2;
    localparam logic [11:0] IDX_RESULT     = 12'hFF3;
    localparam logic [11:0] IDX_INT_STAT   = 12'hFF4;
    localparam logic [11:0] IDX_INT_MASK   = 12'hFF5;
    localparam logic [11:0] IDX_TRIM_IDX   = 12'hFF6;
    localparam logic [11:0] IDX_TRIM_DATA  = 12'hFF7;

    // field positions
    localparam int CTRL_START_BIT  = 0;
    localparam int CTRL_BUSY_BIT   = 0;
    localparam int STAT_VERIFY_BIT = 0;
    localparam int STAT_BADADR_BIT = 1;
    localparam int STAT_FAULT_BIT  = 2;
    localparam int INT_DONE_BIT    = 0;
    localparam int INT_ERR_BIT     = 1;

    typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_VERIFY, ST_DONE} wr_state_t;

endpackage : byte_store_pkg

// >>> hdl/byte_store_write.sv
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1: status bit 2 reports a flash fault seen during the write.
// R2: write beyond store size changes nothing and sets status bit 1.
// R3: programmed byte is read back; mismatch sets status bit 0.
// R4: status bits 7 to 3 always read zero.
// R5: ordinary write lasts 136 us worth of 20 MHz clock cycles.
// R6: every 200th write does maintenance, lasting up to 58 ms.
// R7: write durations are cycle counts, so they scale with clock.
// R8: trim index 00H-1FH selects info byte at index plus 20H.
// R9: trim data reads or writes the byte the trim index selects.
// R10: start with held operands; busy holds until one-cycle done pulse.
module byte_store_write #(
    parameter int MAINT_CYC = byte_store_pkg::MAINT_CYCLES,
    parameter int MAINT_PER = byte_store_pkg::MAINT_PERIOD
) (
    input  wire  logic        pclk,
    input  wire  logic        presetn,
    input  wire  logic        psel,
    input  wire  logic        penable,
    input  wire  logic        pwrite,
    input  wire  logic [13:0] paddr,
    input  wire  logic [31:0] pwdata,
    output logic       [31:0] prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire  logic        flash_fault_in,
    output logic              busy,
    output logic              done,
    output logic        [7:0] status_byte,
    output logic              irq
);

    byte_store_pkg::wr_state_t state_reg, state_next;
    logic [7:0]  store_mem [byte_store_pkg::STORE_SIZE];
    logic [7:0]  trim_mem  [byte_store_pkg::TRIM_COUNT];
    logic [7:0]  addr_reg, data_reg, trim_idx_reg, result_reg;
    logic [1:0]  int_stat_reg, int_mask_reg;
    logic [byte_store_pkg::CNT_W-1:0] cnt_reg;
    logic [7:0]  wcount_reg;
    logic        maint_reg, bad_reg, fault_seen_reg, vfail_reg;
    logic        sync1_reg, sync2_reg, sync3_reg, fault_reg;

    // register decode, shared by read and write paths
    function automatic logic hit(input logic [13:0] a,
                                 input logic [11:0] idx);
        hit = (a[13:2] == idx) && (a[1:0] == 2'b00);
    endfunction : hit

    wire acc      = psel && penable;
    wire wr       = acc && pwrite;
    wire rd       = acc && !pwrite;
    wire h_addr   = hit(paddr, byte_store_pkg::IDX_STORE_ADDR);
    wire h_data   = hit(paddr, byte_store_pkg::IDX_STORE_DATA);
    wire h_ctrl   = hit(paddr, byte_store_pkg::IDX_CTRL);
    wire h_res    = hit(paddr, byte_store_pkg::IDX_RESULT);
    wire h_istat  = hit(paddr, byte_store_pkg::IDX_INT_STAT);
    wire h_imask  = hit(paddr, byte_store_pkg::IDX_INT_MASK);
    wire h_tidx   = hit(paddr, byte_store_pkg::IDX_TRIM_IDX);
    wire h_tdata  = hit(paddr, byte_store_pkg::IDX_TRIM_DATA);
    wire mapped   = h_addr | h_data | h_ctrl | h_res | h_istat | h_imask
                  | h_tidx | h_tdata;
    wire idle     = (state_reg == byte_store_pkg::ST_IDLE);
    // operands are frozen while a write runs, so they stay stable
    wire start    = wr && h_ctrl && pwdata[byte_store_pkg::CTRL_START_BIT]
                  && idle;
    wire addr_bad = (addr_reg >= 8'(byte_store_pkg::STORE_SIZE));
    // period is a parameter so a short run can still reach maintenance;
    // the counter is 8 bits wide, so the period must stay at most 256
    wire maint_go = (wcount_reg == 8'(MAINT_PER - 1));
    // R8: indices above 1FH select nothing
    wire trim_ok  = (trim_idx_reg < 8'(byte_store_pkg::TRIM_COUNT));
    wire [4:0] tsel = trim_idx_reg[4:0];
    wire [5:0] ssel = addr_reg[5:0];
    wire [7:0] trim_rd  = trim_ok ? trim_mem[tsel] : 8'h00;
    wire [7:0] store_rd = store_mem[ssel];
    wire cnt_zero = (cnt_reg == '0);

    // R4: reserved status bits are forced to zero
    wire [7:0] result_next_w = {5'b00000, fault_seen_reg, bad_reg,
                                vfail_reg};
    wire err_evt  = done && (|result_next_w[2:0]);

    // R5 R6 R7: duration chosen at start, in reference clock cycles
    wire [byte_store_pkg::CNT_W-1:0] dur =
        addr_bad ? byte_store_pkg::CNT_W'(byte_store_pkg::BADADDR_CYCLES - 1)
      : maint_go ? byte_store_pkg::CNT_W'(MAINT_CYC - 1)
      :            byte_store_pkg::CNT_W'(byte_store_pkg::WRITE_CYCLES - 1);

    // APB answers in the access cycle; unmapped addresses get pslverr
    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;
    assign prdata  =
        h_addr  ? {24'h000000, addr_reg}
      : h_data  ? {24'h000000, data_reg}
      : h_ctrl  ? {31'h00000000, !idle}
      : h_res   ? {24'h000000, result_reg}
      : h_istat ? {30'h00000000, int_stat_reg}
      : h_imask ? {30'h00000000, int_mask_reg}
      : h_tidx  ? {24'h000000, trim_idx_reg}
      : h_tdata ? {24'h000000, trim_rd}
      :           32'h00000000;

    // R10: busy covers the whole operation, done is the last cycle of it
    assign busy        = !idle;
    assign done        = (state_reg == byte_store_pkg::ST_DONE);
    assign status_byte = result_reg;
    assign irq         = |(int_stat_reg & int_mask_reg);

    // fault pin crosses in: only the 2nd and 3rd stages are compared
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
            fault_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= flash_fault_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            if (sync2_reg == sync3_reg)
                fault_reg <= sync3_reg;
        end
    end

    // write sequencer next state
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            byte_store_pkg::ST_IDLE:   if (start)
                                           state_next = byte_store_pkg::ST_PROG;
            byte_store_pkg::ST_PROG:   if (cnt_zero)
                                           state_next =
                                               byte_store_pkg::ST_VERIFY;
            byte_store_pkg::ST_VERIFY: state_next = byte_store_pkg::ST_DONE;
            byte_store_pkg::ST_DONE:   state_next = byte_store_pkg::ST_IDLE;
            default:                   state_next = byte_store_pkg::ST_IDLE;
        endcase
    end

    // sequencer state, duration counter and per-write flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg      <= byte_store_pkg::ST_IDLE;
            cnt_reg        <= '0;
            bad_reg        <= 1'b0;
            maint_reg      <= 1'b0;
            fault_seen_reg <= 1'b0;
            vfail_reg      <= 1'b0;
            wcount_reg     <= 8'h00;
            result_reg     <= 8'h00;
        end
        else
        begin
            state_reg <= state_next;
            if (start)
            begin
                cnt_reg        <= dur;
                bad_reg        <= addr_bad;
                maint_reg      <= maint_go && !addr_bad;
                fault_seen_reg <= fault_reg;
                vfail_reg      <= 1'b0;
            end
            else if (!cnt_zero)
                cnt_reg <= cnt_reg - 1'b1;
            // R1: any fault seen from start until the cycle before done is remembered
            if (busy && !done && fault_reg)
                fault_seen_reg <= 1'b1;
            // R6: only legal writes count toward maintenance
            if (start && !addr_bad)
                wcount_reg <= maint_go ? 8'h00 : wcount_reg + 8'h01;
            // R3: read back the programmed byte and compare
            if (state_reg == byte_store_pkg::ST_VERIFY && !bad_reg)
                vfail_reg <= (store_rd != data_reg);
            if (done)
                result_reg <= result_next_w;
        end
    end

    // operand, trim and interrupt registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr_reg     <= 8'h00;
            data_reg     <= 8'h00;
            trim_idx_reg <= byte_store_pkg::TRIM_IDX_RESET;
            int_stat_reg <= 2'b00;
            int_mask_reg <= 2'b00;
        end
        else
        begin
            if (wr && h_addr && idle)
                addr_reg <= pwdata[7:0];
            if (wr && h_data && idle)
                data_reg <= pwdata[7:0];
            if (wr && h_tidx)
                trim_idx_reg <= pwdata[7:0];
            if (wr && h_imask)
                int_mask_reg <= pwdata[1:0];
            // read clears, but a same-cycle event still sets its bit
            int_stat_reg <= (int_stat_reg & ~{2{rd && h_istat}})
                          | {err_evt, done};
        end
    end

    // flash cells: store programming only clears bits, trim writes replace the byte; erased state is all ones
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < byte_store_pkg::STORE_SIZE; i++)
                store_mem[i] <= byte_store_pkg::ERASED_BYTE;
            for (int j = 0; j < byte_store_pkg::TRIM_COUNT; j++)
                trim_mem[j] <= byte_store_pkg::ERASED_BYTE;
        end
        else
        begin
            // R2: an out-of-range write never touches the array
            if (state_reg == byte_store_pkg::ST_PROG && cnt_zero && !bad_reg)
                store_mem[ssel] <= store_mem[ssel] & data_reg;
            // R9: trim write lands at info byte TRIM_INFO_BASE + index
            if (wr && h_tdata && trim_ok)
                trim_mem[tsel] <= pwdata[7:0];
        end
    end

    // helper: cycles spent between start and done
    logic [byte_store_pkg::CNT_W-1:0] run_cnt;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run_cnt <= '0;
        else
            run_cnt <= (busy && !done) ? run_cnt + 1'b1 : '0;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // done pulse, status bits, write durations, maintenance and trim checks
    chk_done_one_cycle: assert property (done |=> !done) // R10
        else $error("done lasted more than one cycle");
    chk_busy_ends_done: assert property ($fell(busy) |-> $past(done)) // R10
        else $error("busy dropped without done");
    chk_reserved_zero: assert property (status_byte[7:3] == 5'b00000) // R4
        else $error("reserved status bits not zero");
    chk_bad_addr_flag: assert property ( // R2
        start && addr_bad |-> ##142 done ##1 status_byte[1])
        else $error("bad address write not flagged in time");
    chk_write_time: assert property ( // R5
        done && !maint_reg && !bad_reg |->
        run_cnt == byte_store_pkg::CNT_W'(byte_store_pkg::WRITE_CYCLES + 1))
        else $error("ordinary write duration wrong");
    chk_maint_time: assert property ( // R6
        done && maint_reg |-> run_cnt == byte_store_pkg::CNT_W'(MAINT_CYC + 1))
        else $error("maintenance write duration wrong");
    chk_maint_period: assert property ( // R6
        start && !addr_bad && wcount_reg == 8'(MAINT_PER - 1)
        |=> maint_reg && wcount_reg == 8'h00)
        else $error("maintenance not taken on 200th write");
    chk_fault_flag: assert property ( // R1
        done && fault_seen_reg |=> status_byte[2])
        else $error("flash fault not reported");
    chk_verify_fail: assert property ( // R3
        state_reg == byte_store_pkg::ST_VERIFY && !bad_reg
        && store_rd != data_reg |-> ##2 status_byte[0])
        else $error("readback mismatch not reported");
    chk_trim_write: assert property ( // R9
        wr && h_tdata && trim_ok |=> trim_mem[$past(tsel)] == $past(pwdata[7:0]))
        else $error("trim write not stored");
    chk_trim_range: assert property ( // R8
        rd && h_tdata && !trim_ok |-> prdata == 32'h00000000)
        else $error("out of range trim index returned data");

    // operands, interrupt status and refused stores
    chk_operands_held: assert property ( // R10
        busy |=> $stable(addr_reg) && $stable(data_reg))
        else $error("operands changed during a write");
    chk_done_sets_stat: assert property ( // R10
        done |=> int_stat_reg[byte_store_pkg::INT_DONE_BIT])
        else $error("done did not set interrupt status");
    chk_bad_no_store: assert property ( // R2
        state_reg == byte_store_pkg::ST_PROG && cnt_zero && bad_reg
        |=> $stable(store_rd))
        else $error("out of range write changed the store");

    cov_normal_write: cover property (done && !maint_reg && !bad_reg);
    cov_maint_write:  cover property (done && maint_reg);
    cov_bad_write:    cover property (done && bad_reg);
    cov_irq_raised:   cover property (irq);
    cov_fault_write:  cover property (done && fault_seen_reg);

endmodule : byte_store_write

`default_nettype wire

// >>> dv/flash_fault_model.sv
`timescale 1ns/1ps
`default_nettype none

module flash_fault_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic fault_cmd,
    output logic      fault_pin
);
    // the array reports an error a cycle late, so the sync path sees a lag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fault_pin <= 1'b0;
        else
            fault_pin <= fault_cmd;
    end
endmodule : flash_fault_model

`default_nettype wire

// >>> dv/byte_store_write_and_trim_access_bench.sv
`timescale 1ns/1ps
`default_nettype none

module byte_store_write_and_trim_access_bench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [13:0] paddr = 14'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        fault_cmd = 1'b0;
    logic        fault_pin;
    logic        busy;
    logic        done;
    logic [7:0]  status_byte;
    logic        irq;
    logic        mask_on;
    logic [31:0] r;
    logic        e;
    int          n_errors = 0;
    int          num_checks = 0;

    // short maintenance length and period keep the run small
    localparam int MAINT_SIM  = 300;
    localparam int PERIOD_SIM = 4;

    always #4 pclk = ~pclk;

    byte_store_write #(
        .MAINT_CYC(MAINT_SIM),
        .MAINT_PER(PERIOD_SIM)
    ) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .flash_fault_in(fault_pin),
        .busy(busy), .done(done), .status_byte(status_byte), .irq(irq)
    );

    flash_fault_model u_flash (
        .pclk(pclk), .presetn(presetn), .fault_cmd(fault_cmd),
        .fault_pin(fault_pin)
    );

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic end_sim();
        if (n_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim

    // one apb transfer; entered just after a rising edge, it lets one
    // idle edge pass after the release so no strobe is driven twice
    task automatic apb(input logic w, input logic [11:0] idx,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // full byte write, timed from the idle edge after the start edge to the done pulse
    task automatic do_write(input logic [7:0] a, input logic [7:0] d,
                            input logic [7:0] st, input int dly);
        int k;
        apb(1'b1, byte_store_pkg::IDX_STORE_ADDR, {24'h000000, a});
        apb(1'b1, byte_store_pkg::IDX_STORE_DATA, {24'h000000, d});
        apb(1'b1, byte_store_pkg::IDX_CTRL, 32'h00000001);
        k = 0;
        do
        begin
            @(posedge pclk);
            #1;
            k++;
        end
        while (done !== 1'b1 && k < 5000);
        cmp(32'(k), 32'(dly));
        cmp({31'h0, busy}, 32'h1);
        @(posedge pclk);
        apb(1'b0, byte_store_pkg::IDX_RESULT, 32'h0);
        cmp(r, {24'h000000, st});
        cmp({24'h0, status_byte}, {24'h000000, st});
        cmp({31'h0, irq}, {31'h0, mask_on});
        apb(1'b0, byte_store_pkg::IDX_INT_STAT, 32'h0);
        cmp(r, {30'h0, |st[2:0], 1'b1});
        cmp({31'h0, irq}, 32'h0);
        apb(1'b0, byte_store_pkg::IDX_STORE_ADDR, 32'h0);
        cmp(r, {24'h000000, a});
    endtask : do_write

    // trim window: reset values, both ends of the index range, refusal
    task automatic trim_test();
        apb(1'b0, byte_store_pkg::IDX_TRIM_IDX, 32'h0);
        cmp(r, 32'h00000000);
        apb(1'b0, byte_store_pkg::IDX_TRIM_DATA, 32'h0);
        cmp(r, 32'h000000FF);
        apb(1'b1, byte_store_pkg::IDX_TRIM_IDX, 32'h0000001F);
        apb(1'b1, byte_store_pkg::IDX_TRIM_DATA, 32'h0000003C);
        apb(1'b0, byte_store_pkg::IDX_TRIM_DATA, 32'h0);
        cmp(r, 32'h0000003C);
        apb(1'b1, byte_store_pkg::IDX_TRIM_IDX, 32'h00000000);
        apb(1'b0, byte_store_pkg::IDX_TRIM_DATA, 32'h0);
        cmp(r, 32'h000000FF);
        apb(1'b1, byte_store_pkg::IDX_TRIM_IDX, 32'h00000020);
        apb(1'b1, byte_store_pkg::IDX_TRIM_DATA, 32'h00000011);
        apb(1'b0, byte_store_pkg::IDX_TRIM_DATA, 32'h0);
        cmp(r, 32'h00000000);
        apb(1'b0, byte_store_pkg::IDX_TRIM_IDX, 32'h0);
        cmp(r, 32'h00000020);
        // an unmapped word must answer with an error and zero data
        apb(1'b0, 12'h000, 32'h0);
        cmp({31'h0, e}, 32'h1);
        cmp(r, 32'h00000000);
    endtask : trim_test

    // fault pin held across a legal write
    task automatic fault_test();
        fault_cmd <= 1'b1;
        repeat (6) @(posedge pclk);
        do_write(8'h06, 8'h12, 8'h04, byte_store_pkg::WRITE_CYCLES);
        fault_cmd <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask : fault_test

    // watchdog sized well above the six timed writes
    initial
    begin
        #300000;
        n_errors++;
        end_sim();
    end

    initial
    begin
        mask_on = 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        trim_test();
        apb(1'b1, byte_store_pkg::IDX_INT_MASK, 32'h00000003);
        do_write(8'h05, 8'hA5, 8'h00, byte_store_pkg::WRITE_CYCLES);
        do_write(8'h05, 8'hFF, 8'h01, byte_store_pkg::WRITE_CYCLES);
        do_write(8'h40, 8'h00, 8'h02, byte_store_pkg::BADADDR_CYCLES);
        fault_test();
        // masked off: status still set, output stays low
        mask_on = 1'b0;
        apb(1'b1, byte_store_pkg::IDX_INT_MASK, 32'h00000000);
        // fourth legal write of the short period runs maintenance
        do_write(8'h07, 8'h3C, 8'h00, MAINT_SIM);
        // counter restarts: the next legal write is ordinary again
        do_write(8'h08, 8'h5A, 8'h00, byte_store_pkg::WRITE_CYCLES);
        end_sim();
    end
endmodule : byte_store_write_and_trim_access_bench

`default_nettype wire
